// *** serial_control_port.v ***
// serial control port: spi or i2c slave sharing one shift register
// What this block does
// - select pin low spi, high i2c
// - two i2c address strap bits take the synchronisers' reset value 1, not the pins
// - one 24-bit shift register for both
// - spi samples on rising clock, msb first
// - spi keeps only last 24 bits
// - short frames accepted without padding
// - output shifts on falling edge, msb first
// - readout unaffected until frame completes
// - spi commits after select rises
// - low four bits address control register
// - i2c answers only its own address
// - i2c transfers of one to three bytes
// - receiver acknowledges each byte
// - i2c read data shifts on falling edge
// - i2c commits after stop condition
// - address 11000, strap bits 2 and 1
// - sixteen data registers, selected index read
// - spi mode zero timing
// - open-drain output, disabled at reset
// - spi reads: first bit repeated, tail 110
// - soft reset holds until cleared
`timescale 1ns/1ps
`include "sercp_regs.vh"
module serial_control_port
(
  ref_clk,
  nrst,
  interface_select_pin,
  sclk_pin,
  mosi_sda_in,
  sda_out,
  sda_oe,
  select_addr_bit1_in,
  serial_out_addr_bit2_in,
  serial_out_addr_bit2_out,
  serial_out_addr_bit2_oe,
  data_reg_flat,
  cr_flat,
  cr_write_strobe,
  soft_reset_bit
);
  input          ref_clk;
  input          nrst;
  input          interface_select_pin;
  input          sclk_pin;
  input          mosi_sda_in;
  output         sda_out;
  output         sda_oe;
  input          select_addr_bit1_in;
  input          serial_out_addr_bit2_in;
  output         serial_out_addr_bit2_out;
  output         serial_out_addr_bit2_oe;
  input  [383:0] data_reg_flat;
  output [239:0] cr_flat;
  output [11:0]  cr_write_strobe;
  output         soft_reset_bit;

  localparam S_IDLE = 6'h01;
  localparam S_ADDR = 6'h02;
  localparam S_WR   = 6'h04;
  localparam S_RD   = 6'h08;
  localparam S_ACK  = 6'h10;
  localparam S_SKIP = 6'h20;

  wire mode_i2c;
  wire clk_rise;
  wire clk_fall;
  wire clk_lvl;
  wire dat_lvl;
  wire dat_rise;
  wire dat_fall;
  wire sel_lvl;
  wire sel_rise;
  wire sel_fall;
  wire so_lvl;

  edge_sync #(.INIT(1'b1)) u_bsel (.ref_clk(ref_clk), .nrst(nrst),
    .pin(interface_select_pin), .level(mode_i2c), .rise(), .fall());
  edge_sync #(.INIT(1'b0)) u_clk (.ref_clk(ref_clk), .nrst(nrst),
    .pin(sclk_pin), .level(clk_lvl), .rise(clk_rise), .fall(clk_fall));
  edge_sync #(.INIT(1'b1)) u_dat (.ref_clk(ref_clk), .nrst(nrst),
    .pin(mosi_sda_in), .level(dat_lvl), .rise(dat_rise), .fall(dat_fall));
  edge_sync #(.INIT(1'b1)) u_sel (.ref_clk(ref_clk), .nrst(nrst),
    .pin(select_addr_bit1_in), .level(sel_lvl), .rise(sel_rise), .fall(sel_fall));
  edge_sync #(.INIT(1'b1)) u_so (.ref_clk(ref_clk), .nrst(nrst),
    .pin(serial_out_addr_bit2_in), .level(so_lvl), .rise(), .fall());

  reg [23:0]  shift_reg;
  reg [23:0]  out_reg;
  reg         first_rep_reg;
  reg [5:0]   state_reg;
  reg [2:0]   bitcnt_reg;
  reg [1:0]   bytecnt_reg;
  reg [7:0]   byte_reg;
  reg         bit_seen_reg;
  reg         rw_reg;
  reg         ack_ok_reg;
  reg         pending_reg;
  reg [239:0] cr_reg;
  reg [11:0]  strobe_reg;
  reg         sda_oe_reg;
  reg         so_oe_reg;
  reg [1:0]   strap_reg;
  reg         strap_done_reg;
  reg [3:0]   sel_idx_reg;
  reg         so_en_reg;
  reg         srst_reg;

  // read word: selected data register, tail forced to 110
  function [23:0] readback;
    input [383:0] regs;
    input [3:0]   idx;
    reg   [23:0]  w;
    begin
      w = regs[idx*24 +: 24];
      // tail one bit up: the repeated first bit pushes bit 0 out of a 24-bit read
      readback = {w[23:4], `READBACK_TAIL, 1'b1};
    end
  endfunction

  function cr_defined;
    input [3:0] a;
    begin
      cr_defined = (a < `CR_COUNT);
    end
  endfunction

  wire [23:0] rb_word;
  wire        spi_active;
  wire        start_c;
  wire        stop_c;
  wire [6:0]  my_addr;
  assign rb_word    = readback(data_reg_flat, sel_idx_reg);
  assign spi_active = ~mode_i2c & ~sel_lvl;
  assign start_c    = mode_i2c & dat_fall & clk_lvl;
  assign stop_c     = mode_i2c & dat_rise & clk_lvl;
  assign my_addr    = {`I2C_ADDR_FIXED, strap_reg};

  // commit the shifted word; addresses past the table are dropped
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cr_reg      <= 240'h0;
      strobe_reg  <= 12'h000;
      sel_idx_reg <= 4'h0;
      so_en_reg   <= 1'b0;
      srst_reg    <= 1'b0;
    end
    else
    begin
      strobe_reg <= 12'h000;
      if (pending_reg && cr_defined(shift_reg[3:0]))
      begin
        cr_reg[shift_reg[3:0]*20 +: 20] <= shift_reg[23:4];
        strobe_reg[shift_reg[3:0]]      <= 1'b1;
        if (shift_reg[3:0] == `CR_DATA_SEL)
          sel_idx_reg <= shift_reg[7:4];
        if (shift_reg[3:0] == `CR_RST_SO)
        begin
          srst_reg  <= shift_reg[`RS_BIT];
          so_en_reg <= shift_reg[`SO_EN_BIT];
        end
      end
    end
  end

  // straps loaded once, in the first cycle after reset release, from the synchronisers still at reset value 1; pins later become bus lines
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      strap_reg      <= 2'b00;
      strap_done_reg <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      strap_reg      <= {so_lvl, sel_lvl};
      strap_done_reg <= 1'b1;
    end
  end

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      shift_reg     <= 24'h0;
      out_reg       <= 24'h0;
      first_rep_reg <= 1'b0;
      state_reg     <= S_IDLE;
      bitcnt_reg    <= 3'h0;
      bytecnt_reg   <= 2'h0;
      rw_reg        <= 1'b0;
      ack_ok_reg    <= 1'b0;
      pending_reg   <= 1'b0;
      sda_oe_reg    <= 1'b0;
      so_oe_reg     <= 1'b0;
      byte_reg      <= 8'h00;
      bit_seen_reg  <= 1'b0;
    end
    else
    begin
      pending_reg <= 1'b0;
      if (!mode_i2c)
      begin
        sda_oe_reg <= 1'b0;
        state_reg  <= S_IDLE;
        if (sel_fall)
        begin
          out_reg       <= rb_word;
          first_rep_reg <= 1'b1;
          so_oe_reg     <= so_en_reg & ~rb_word[23];
        end
        else if (spi_active && clk_rise)
          shift_reg <= {shift_reg[22:0], dat_lvl};
        else if (spi_active && clk_fall)
        begin
          if (first_rep_reg)
            first_rep_reg <= 1'b0;
          else
          begin
            out_reg   <= {out_reg[22:0], 1'b1};
            so_oe_reg <= so_en_reg & ~out_reg[22];
          end
        end
        if (sel_rise)
        begin
          pending_reg <= 1'b1;
          so_oe_reg   <= 1'b0;
        end
      end
      else
      begin
        so_oe_reg <= 1'b0;
        if (start_c)
        begin
          state_reg  <= S_ADDR;
          bitcnt_reg <= 3'h0;
          bytecnt_reg  <= 2'h0;
          bit_seen_reg <= 1'b0;
          sda_oe_reg <= 1'b0;
        end
        else if (stop_c)
        begin
          // short frames leave fewer bytes in the low end
          pending_reg <= (state_reg != S_IDLE) && ack_ok_reg && !rw_reg
                         && (bytecnt_reg != 2'h0);
          state_reg   <= S_IDLE;
          sda_oe_reg  <= 1'b0;
        end
        else
        begin
          case (state_reg)
            S_IDLE:
              sda_oe_reg <= 1'b0;
            S_ADDR, S_WR:
              if (clk_rise)
              begin
                // staged per byte so the clock rise before a stop never shifts the word
                byte_reg     <= {byte_reg[6:0], dat_lvl};
                bit_seen_reg <= 1'b1;
                bitcnt_reg   <= bitcnt_reg + 3'h1;
              end
              else if (clk_fall && bitcnt_reg == 3'h0 && state_reg == S_ADDR &&
                       ack_ok_reg == 1'b0 && shift_reg[7:1] == my_addr &&
                       bytecnt_reg == 2'h3)
                state_reg <= S_ADDR;
              else if (clk_fall && bitcnt_reg == 3'h0 && bit_seen_reg && bytecnt_reg != 2'h3)
              begin
                if (state_reg == S_ADDR)
                begin
                  if (byte_reg[7:1] == my_addr)
                  begin
                    rw_reg      <= byte_reg[0];
                    ack_ok_reg  <= 1'b1;
                    bytecnt_reg <= 2'h0;
                    out_reg     <= rb_word;
                    sda_oe_reg  <= 1'b1;
                    state_reg   <= S_ACK;
                  end
                  else
                  begin
                    ack_ok_reg <= 1'b0;
                    state_reg  <= S_SKIP;
                  end
                end
                else
                begin
                  bytecnt_reg <= bytecnt_reg + 2'h1;
                  shift_reg   <= {shift_reg[15:0], byte_reg};
                  sda_oe_reg  <= 1'b1;
                  state_reg   <= S_ACK;
                end
              end
            S_ACK:
              if (clk_fall)
              begin
                bitcnt_reg   <= 3'h0;
                bit_seen_reg <= 1'b0;
                if (rw_reg)
                begin
                  state_reg  <= S_RD;
                  sda_oe_reg <= ~out_reg[23];
                end
                else
                begin
                  state_reg  <= S_WR;
                  sda_oe_reg <= 1'b0;
                end
              end
            S_RD:
              if (clk_rise && bitcnt_reg == 3'h7)
              begin
                bitcnt_reg <= 3'h0;
                if (dat_lvl)
                  state_reg <= S_SKIP; // line high at the eighth data bit ends the read
              end
              else if (clk_rise)
                bitcnt_reg <= bitcnt_reg + 3'h1;
              else if (clk_fall)
              begin
                out_reg <= {out_reg[22:0], 1'b1};
                if (bitcnt_reg == 3'h0)
                begin
                  sda_oe_reg <= 1'b0;
                  state_reg  <= S_ACK;
                end
                else
                  sda_oe_reg <= ~out_reg[22];
              end
            S_SKIP:
              sda_oe_reg <= 1'b0;
            default:
              state_reg <= S_IDLE;
          endcase
        end
      end
    end
  end

  assign cr_flat                  = cr_reg;
  assign cr_write_strobe          = strobe_reg;
  assign soft_reset_bit           = srst_reg;
  assign sda_out                  = 1'b0;
  assign sda_oe                   = sda_oe_reg;
  assign serial_out_addr_bit2_out = 1'b0;
  assign serial_out_addr_bit2_oe  = so_oe_reg;
endmodule

// *** sercp_regs.vh ***
// constants for the dual spi/i2c serial control port
`ifndef SERCP_REGS_VH
`define SERCP_REGS_VH
`define SR_WIDTH        24
`define CR_COUNT        12
`define CR_RST_SO       4'h4
`define CR_DATA_SEL     4'hB
`define RS_BIT          4
`define SO_EN_BIT       5
`define I2C_ADDR_FIXED  5'h18
`define READBACK_TAIL   3'h6
`endif

// *** edge_sync.v ***
// two-flop synchroniser with edge detection for one pin
`timescale 1ns/1ps
module edge_sync
(
  ref_clk,
  nrst,
  pin,
  level,
  rise,
  fall
);
  input      ref_clk;
  input      nrst;
  input      pin;
  output     level;
  output     rise;
  output     fall;
  parameter  INIT = 1'b1;
  reg        meta_reg;
  reg        sync_reg;
  reg        last_reg;
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= INIT;
      sync_reg <= INIT;
      last_reg <= INIT;
    end
    else
    begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end
  assign level = sync_reg;
  assign rise  = sync_reg & ~last_reg;
  assign fall  = ~sync_reg & last_reg;
endmodule

// *** serial_control_port_properties.sv ***
// concurrent checks on the serial control port pins
`timescale 1ns/1ps
module serial_control_port_props
(
  input wire logic         ref_clk,
  input wire logic         nrst,
  input wire logic         interface_select_pin,
  input wire logic         select_addr_bit1_in,
  input wire logic         sda_out,
  input wire logic         sda_oe,
  input wire logic         serial_out_addr_bit2_out,
  input wire logic         serial_out_addr_bit2_oe,
  input wire logic [239:0] cr_flat,
  input wire logic [11:0]  cr_write_strobe,
  input wire logic         soft_reset_bit
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_open_drain;
    sda_out == 1'b0 && serial_out_addr_bit2_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin level not low");
  property p_reset_quiet;
    $rose(nrst) |-> !serial_out_addr_bit2_oe && !sda_oe && !soft_reset_bit;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("busy after reset");
  property p_one_strobe;
    $onehot0(cr_write_strobe);
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("two strobes");
  property p_strobe_pulse;
    |cr_write_strobe |=> cr_write_strobe == 12'h000;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
  property p_commit_after_select;
    (|cr_write_strobe) && !interface_select_pin |-> $past(select_addr_bit1_in, 2);
  endproperty
  a_commit_after_select: assert property (p_commit_after_select) else $error("early commit");
  property p_cr_holds;
    $changed(cr_flat) |-> |cr_write_strobe;
  endproperty
  a_cr_holds: assert property (p_cr_holds) else $error("cr changed alone");
  property p_soft_reset;
    $changed(soft_reset_bit) |-> cr_write_strobe[4] && soft_reset_bit == cr_flat[80];
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong");
  property p_so_enable;
    serial_out_addr_bit2_oe |-> cr_flat[81];
  endproperty
  a_so_enable: assert property (p_so_enable) else $error("drive while disabled");
  property p_idle_release;
    (!interface_select_pin && select_addr_bit1_in) [*6] |-> !serial_out_addr_bit2_oe;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("drive while idle");
  property p_spi_no_sda;
    (!interface_select_pin) [*4] |-> !sda_oe;
  endproperty
  a_spi_no_sda: assert property (p_spi_no_sda) else $error("sda driven in spi");
  c_cr4: cover property (cr_write_strobe[4]);
  c_cr11: cover property (cr_write_strobe[11]);
  c_drive: cover property ($rose(serial_out_addr_bit2_oe));
endmodule

bind serial_control_port serial_control_port_props u_serial_control_port_props
(
  .ref_clk(ref_clk), .nrst(nrst), .interface_select_pin(interface_select_pin),
  .select_addr_bit1_in(select_addr_bit1_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .serial_out_addr_bit2_out(serial_out_addr_bit2_out),
  .serial_out_addr_bit2_oe(serial_out_addr_bit2_oe), .cr_flat(cr_flat),
  .cr_write_strobe(cr_write_strobe), .soft_reset_bit(soft_reset_bit)
);

// *** spi_host.sv ***
// spi master model, mode zero, sclk period 160 ns
`timescale 1ns/1ps
module spi_host
(
  input  wire ref_clk,
  input  wire miso,
  input  wire sda,
  output reg  sclk,
  output reg  ss_n,
  output reg  mosi
);
  task automatic half;
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic xfer(input [31:0] w, input integer n, output [23:0] rd);
    integer i;
    begin
      ss_n = 1'b0;
      rd = 24'h0;
      for (i = n - 1; i >= 0; i = i - 1)
      begin
        mosi = w[i];
        half;
        sclk = 1'b1;
        rd = {rd[22:0], miso};
        half;
        sclk = 1'b0;
      end
      half;
      // released line must not keep its last bit
      mosi = ~mosi;
      ss_n = 1'b1;
      half;
    end
  endtask
  // two-wire write: start, n bits msb first, ack slot after every byte, stop
  task automatic i2c_wr(input [31:0] w, input integer n, output [3:0] nak);
    integer i;
    begin
      nak = 4'h0;
      sclk = 1'b1;
      mosi = 1'b1;
      half;
      mosi = 1'b0;
      half;
      sclk = 1'b0;
      for (i = n - 1; i >= 0; i = i - 1)
      begin
        mosi = w[i];
        half;
        sclk = 1'b1;
        half;
        sclk = 1'b0;
        if (i % 8 == 0)
        begin
          mosi = 1'b1;
          half;
          sclk = 1'b1;
          nak = {nak[2:0], sda};
          half;
          sclk = 1'b0;
        end
      end
      mosi = 1'b0;
      half;
      sclk = 1'b1;
      half;
      mosi = 1'b1;
      half;
    end
  endtask
  initial
  begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
endmodule

// *** tb_top.sv ***
// spi and i2c bench for the serial control port
`timescale 1ns/1ps
module tb_top;
  reg          ref_clk;
  reg          nrst;
  reg          interface_select_pin;
  reg  [383:0] data_reg_flat;
  wire         sclk;
  wire         ss_n;
  wire         mosi;
  wire         miso;
  wire         so_oe;
  wire         sda_oe_w;
  wire         sda_line;
  logic [3:0]  nak;
  wire [239:0] cr_flat;
  wire [11:0]  cr_write_strobe;
  wire         soft_reset_bit;
  logic [43:0] exp_q[$];
  logic [43:0] e;
  logic [31:0] w;
  logic [23:0] rd;
  integer      mismatches;
  integer      samples_checked;
  integer      j;
  integer      k;
  // pull-up on the shared output line
  assign miso = so_oe ? 1'b0 : 1'b1;
  assign sda_line = mosi & ~sda_oe_w;
  spi_host u_spi_host (.ref_clk(ref_clk), .miso(miso), .sda(sda_line), .sclk(sclk),
    .ss_n(ss_n), .mosi(mosi));
  serial_control_port u_serial_control_port
  (
    .ref_clk(ref_clk), .nrst(nrst), .interface_select_pin(interface_select_pin),
    .sclk_pin(sclk), .mosi_sda_in(sda_line), .sda_out(), .sda_oe(sda_oe_w),
    .select_addr_bit1_in(ss_n), .serial_out_addr_bit2_in(miso),
    .serial_out_addr_bit2_out(), .serial_out_addr_bit2_oe(so_oe),
    .data_reg_flat(data_reg_flat), .cr_flat(cr_flat),
    .cr_write_strobe(cr_write_strobe), .soft_reset_bit(soft_reset_bit)
  );
  task check(input string what, input [23:0] seen, input [23:0] expv);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== expv)
      begin
        mismatches = mismatches + 1;
        $display("wrong value %0s expected %h seen %h", what, expv, seen);
      end
    end
  endtask
  task wr(input [31:0] v, input integer n, input [19:0] m);
    begin
      if (v[3:0] < 4'hC)
        exp_q.push_back({v[3:0], v[23:4], m});
      u_spi_host.xfer(v, n, rd);
      repeat (10) @(negedge ref_clk);
    end
  endtask
  function [23:0] rb(input [3:0] i);
    reg [23:0] d;
    begin
      d = data_reg_flat[i*24 +: 24];
      rb = {d[23], d[23:4], 3'b110};
    end
  endfunction
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // commits are matched in order against the notes
  always @(negedge ref_clk)
    if (nrst === 1'b1 && cr_write_strobe !== 12'h000)
    begin
      e = exp_q.size() ? exp_q.pop_front() : {4'hF, 40'h0};
      check("strobe", cr_write_strobe, 12'h001 << e[43:40]);
      check("payload", cr_flat[e[43:40]*20 +: 20] & e[19:0], e[39:20] & e[19:0]);
    end
  initial
  begin
    nrst = 1'b0;
    interface_select_pin = 1'b0;
    data_reg_flat = 384'h0;
    mismatches = 0;
    samples_checked = 0;
    j = $urandom(32'h3E134DE7);
    repeat (20) @(negedge ref_clk);
    nrst = 1'b1;
    for (j = 0; j < 12; j = j + 1)
      data_reg_flat[j*32 +: 32] = $urandom;
    repeat (8) @(negedge ref_clk);
    check("cr after reset", cr_flat[23:0], 24'h0);
    $display("test reset done");
    wr(32'h14, 24, 20'hFFFFF);
    check("soft reset set", soft_reset_bit, 1'b1);
    check("disabled output", rd, 24'hFFFFFF);
    k = $urandom % 16;
    wr({16'h0, k[3:0], 4'hB}, 24, 20'hFFFFF);
    wr(32'h24, 24, 20'hFFFFF);
    check("soft reset clear", soft_reset_bit, 1'b0);
    $display("test soft reset done");
    for (j = 0; j < 5; j = j + 1)
    begin
      w = $urandom;
      w[3:0] = 4'hB;
      wr(w, j ? 24 : 32, 20'hFFFFF);
      if (j > 0)
        check("readback", rd, rb(k[3:0]));
      k = w[7:4];
    end
    $display("test readback done");
    for (j = 0; j < 16; j = j + 1)
    begin
      w = $urandom;
      w[3:0] = j;
      if (j == 4)
        w[5:4] = 2'b10;
      wr(w, 24, 20'hFFFFF);
    end
    w = $urandom;
    w[3:0] = 4'h2;
    wr(w, 8, 20'h0000F);
    interface_select_pin = 1'b1;
    repeat (5) @(negedge ref_clk);
    w = $urandom;
    w[3:0] = 4'h7;
    exp_q.push_back({w[3:0], w[23:4], 20'hFFFFF});
    u_spi_host.i2c_wr({8'hC6, w[23:0]}, 32, nak);
    check("i2c ack", nak, 4'h0);
    u_spi_host.i2c_wr({8'hC2, w[23:0]}, 32, nak);
    check("foreign address", nak, 4'hF);
    repeat (10) @(negedge ref_clk);
    $display("test i2c done");
    check("pending writes", exp_q.size(), 24'h0);
    $display("test addresses done");
    give_verdict;
  end
endmodule
